// ---- dacsc_pkg.sv ----
`default_nettype none
package dacsc_pkg;

    // ****************************************
    // frame layout
    // ****************************************
    localparam int FRAME_BITS  = 16;
    localparam int DATA_BITS   = 12;
    localparam int CTRL_MSB    = 15;
    localparam int CTRL_LSB    = 13;
    localparam int DATA_MSB    = 12;
    localparam int DATA_LSB    = 1;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [2:0] CMD_NOP      = 3'h0;
    localparam logic [2:0] CMD_LOAD_IN  = 3'h1;
    localparam logic [2:0] CMD_LOAD_ALL = 3'h2;
    localparam logic [2:0] CMD_UPDATE   = 3'h3;
    localparam logic [2:0] CMD_UOUT_LOW  = 3'h4;
    localparam logic [2:0] CMD_SHUTDOWN  = 3'h5;
    localparam logic [2:0] CMD_UOUT_HIGH = 3'h6;
    localparam logic [2:0] CMD_MODE     = 3'h7;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [11:0] CODE_ZERO     = 12'h000;
    localparam logic [11:0] CODE_MIDSCALE = 12'h800;
    localparam logic [15:0] SHIFT_RESET   = 16'h0000;
    // idle level of each synced pin: cs_n, sclk, din, clear_n, select, lockout, powerdown
    localparam logic [6:0]  PIN_IDLE      = 7'h4a;
    // settle wait after wake, external reference, in mclk cycles
    localparam int          WAKE_SETTLE_CYCLES = 400;

    // ****************************************
    // grouped pins
    // ****************************************
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } dacsc_link_t;

    typedef struct packed {
        logic [11:0] code;
        logic        shutdown;
        logic        user_output_pin;
        logic        dout_mode1;
    } dacsc_state_t;

endpackage
`default_nettype wire

// ---- dacsc_core.sv ----
// Functional notes
// - frame is 16 bits, control, data, sub-bit
// - 16-bit shift register, shifted out on dout
// - sample din on sclk rise while selected
// - accept data only while chip select low
// - decode command on chip select rise
// - code 001 loads input register only
// - code 010 loads both, exits shutdown
// - code 011 copies input to dac, wakes
// - code 101 shuts down if lockout high
// - codes 100/110 drive user output low/high
// - code 111, data msb one: mode 1
// - code 111, top bits zero: mode 0
// - shutdown tristates output, link stays alive
// - shutdown keeps input register contents
// - lockout low refuses any shutdown
// - lockout falling edge wakes from shutdown
// - powerdown pin high enters, low stays
// - clear resets dac, ends shutdown
// - reset value midscale or zero by pin
// - dout lag 16 or 15.5 clocks
`timescale 1ns/1ns
`default_nettype none
module dacsc_core
    import dacsc_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // serial link pins
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        din,
    output var  logic        dout,
    // control pins
    input  wire logic        clear_n,
    input  wire logic        reset_value_select,
    input  wire logic        shutdown_lockout_n,
    input  wire logic        powerdown_pin,
    // status outputs
    output var  logic        user_output_pin,
    output var  logic [11:0] dac_code,
    output var  logic [11:0] input_code,
    output var  logic        dac_output_enable,
    output var  logic        shutdown,
    output var  logic        dout_mode1
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam int NPIN = 7;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_q;
    logic [NPIN-1:0] sync2_q;
    logic [NPIN-1:0] prev_q;

    assign pin_raw = {cs_n, sclk, din, clear_n, reset_value_select, shutdown_lockout_n, powerdown_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    sync1_q[gi] <= PIN_IDLE[gi];
                    sync2_q[gi] <= PIN_IDLE[gi];
                    prev_q[gi]  <= PIN_IDLE[gi];
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    prev_q[gi]  <= sync2_q[gi];
                end
            end
        end
    endgenerate

    dacsc_link_t link_s;
    dacsc_link_t link_p;
    logic        clear_n_s;
    logic        rsel_s;
    logic        lock_n_s;
    logic        lock_n_p;
    logic        powerdown_s;

    assign link_s      = sync2_q[6:4];
    assign link_p      = prev_q[6:4];
    assign clear_n_s   = sync2_q[3];
    assign rsel_s      = sync2_q[2];
    assign lock_n_s    = sync2_q[1];
    assign lock_n_p    = prev_q[1];
    assign powerdown_s = sync2_q[0];

    // ****************************************
    // edge decode
    // ****************************************
    wire sclk_rise = link_s.sclk & ~link_p.sclk;
    wire sclk_fall = ~link_s.sclk & link_p.sclk;
    wire selected  = ~link_s.cs_n;
    wire cs_rise   = link_s.cs_n & ~link_p.cs_n;
    wire lock_fall = ~lock_n_s & lock_n_p;
    wire shift_en  = selected & sclk_rise;

    // ****************************************
    // shift register
    // ****************************************
    logic [15:0] shift_q;
    logic [15:0] shift_d;
    assign shift_d = {shift_q[14:0], link_s.din};

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            shift_q <= SHIFT_RESET;
        end else if (shift_en) begin
            shift_q <= shift_d;
        end
    end

    // ****************************************
    // command decode
    // ****************************************
    wire [2:0]  cmd      = shift_q[CTRL_MSB:CTRL_LSB];
    wire [11:0] data     = shift_q[DATA_MSB:DATA_LSB];
    wire        do_cmd   = cs_rise;
    wire        c_ldin   = do_cmd & ((cmd == CMD_LOAD_IN) | (cmd == CMD_LOAD_ALL));
    wire        c_ldall  = do_cmd & (cmd == CMD_LOAD_ALL);
    wire        c_upd    = do_cmd & (cmd == CMD_UPDATE);
    wire        c_sd     = do_cmd & (cmd == CMD_SHUTDOWN) & lock_n_s;
    wire        c_uout_lo = do_cmd & (cmd == CMD_UOUT_LOW);
    wire        c_uout_hi = do_cmd & (cmd == CMD_UOUT_HIGH);
    wire        c_m1     = do_cmd & (cmd == CMD_MODE) & data[11];
    wire        c_m0     = do_cmd & (cmd == CMD_MODE) & (data[11:10] == 2'h0);
    wire        clearing = ~clear_n_s;
    wire [11:0] rst_code = rsel_s ? CODE_MIDSCALE : CODE_ZERO;
    wire        wake     = c_ldall | c_upd | clearing | lock_fall;
    wire        sd_enter = (c_sd | powerdown_s) & lock_n_s;

    // ****************************************
    // registers and state
    // ****************************************
    logic [11:0] in_q;
    logic [11:0] in_d;
    logic [11:0] dac_q;
    logic [11:0] dac_d;
    logic        sd_q;
    logic        sd_d;
    logic        uout_q;
    logic        uout_d;
    logic        mode1_q;
    logic        mode1_d;
    logic        dout_q;
    logic        dout_d;

    // input register untouched by shutdown
    assign in_d    = clearing ? rst_code : (c_ldin ? data : in_q);
    assign dac_d   = clearing ? rst_code : c_ldall ? data : c_upd ? in_q : dac_q;
    // entering wins over pin-held level only when no wake source this cycle
    assign sd_d    = wake ? 1'b0 : (sd_enter ? 1'b1 : sd_q);
    assign uout_d  = clearing ? 1'b0 : c_uout_hi ? 1'b1 : c_uout_lo ? 1'b0 : uout_q;
    assign mode1_d = c_m1 ? 1'b1 : c_m0 ? 1'b0 : mode1_q;
    // mode 0 moves dout on falls, mode 1 on rises
    assign dout_d  = (mode1_q ? sclk_rise : sclk_fall) & selected ? shift_q[15] : dout_q;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            in_q    <= CODE_ZERO;
            dac_q   <= CODE_ZERO;
            sd_q    <= 1'b0;
            uout_q  <= 1'b0;
            mode1_q <= 1'b0;
            dout_q  <= 1'b0;
        end else begin
            in_q    <= in_d;
            dac_q   <= dac_d;
            sd_q    <= sd_d;
            uout_q  <= uout_d;
            mode1_q <= mode1_d;
            dout_q  <= dout_d;
        end
    end

    // strap caught once after reset release
    logic strap_done_q;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            strap_done_q <= 1'b0;
        end else begin
            strap_done_q <= 1'b1;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    logic [11:0] dac_out_q;
    logic [11:0] in_out_q;
    logic        oe_q;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            dac_out_q <= CODE_ZERO;
            in_out_q  <= CODE_ZERO;
            oe_q      <= 1'b0;
        end else begin
            dac_out_q <= strap_done_q ? dac_d : rst_code;
            in_out_q  <= strap_done_q ? in_d : rst_code;
            oe_q      <= ~sd_d;
        end
    end

    assign dout              = dout_q;
    assign user_output_pin   = uout_q;
    assign dac_code          = dac_out_q;
    assign input_code        = in_out_q;
    assign dac_output_enable = oe_q;
    assign shutdown          = sd_q;
    assign dout_mode1        = mode1_q;

    // ****************************************
    // assertions
    // ****************************************
    sequence s_sd_cmd;
        do_cmd && cmd == CMD_SHUTDOWN && lock_n_s && !wake;
    endsequence

    sequence s_exit_cmd;
        (c_ldall || c_upd) && !clearing;
    endsequence

    sequence s_mode_odd;
        do_cmd && cmd == CMD_MODE && data[11:10] == 2'h1;
    endsequence

    cmd_shutdown_a: assert property (@(posedge mclk) disable iff (reset)
        s_sd_cmd |=> shutdown)
        else $error("shutdown command ignored");

    lockout_block_a: assert property (@(posedge mclk) disable iff (reset)
        (!lock_n_s && !sd_q) |=> !shutdown)
        else $error("shutdown entered under lockout");

    lock_wake_a: assert property (@(posedge mclk) disable iff (reset)
        (lock_fall && sd_q) |=> !shutdown ##1 dac_output_enable)
        else $error("lockout edge did not wake");

    load_input_a: assert property (@(posedge mclk) disable iff (reset)
        (do_cmd && cmd == CMD_LOAD_IN && clear_n_s) |=> (in_q == $past(data)) && $stable(dac_q))
        else $error("load input wrong");

    load_both_a: assert property (@(posedge mclk) disable iff (reset)
        (do_cmd && cmd == CMD_LOAD_ALL && clear_n_s) |=> dac_q == $past(data) && in_q == dac_q && !shutdown)
        else $error("load both wrong");

    update_dac_a: assert property (@(posedge mclk) disable iff (reset)
        (c_upd && clear_n_s) |=> dac_q == $past(in_q) && !shutdown)
        else $error("update wrong");

    update_keep_a: assert property (@(posedge mclk) disable iff (reset)
        (c_upd && clear_n_s) |=> $stable(in_q))
        else $error("update changed input register");

    exit_cmd_a: assert property (@(posedge mclk) disable iff (reset)
        s_exit_cmd |=> !shutdown && dac_output_enable)
        else $error("exit command did not wake");

    uout_high_a: assert property (@(posedge mclk) disable iff (reset)
        (c_uout_hi && clear_n_s) |=> user_output_pin [*2])
        else $error("user output not high");

    uout_low_a: assert property (@(posedge mclk) disable iff (reset)
        (c_uout_lo && clear_n_s) |=> !user_output_pin)
        else $error("user output not low");

    clear_uout_a: assert property (@(posedge mclk) disable iff (reset)
        clearing |=> !user_output_pin)
        else $error("clear left user output high");

    mode_sel_a: assert property (@(posedge mclk) disable iff (reset)
        c_m1 |=> dout_mode1)
        else $error("mode 1 not selected");

    mode_zero_a: assert property (@(posedge mclk) disable iff (reset)
        c_m0 |=> !dout_mode1)
        else $error("mode 0 not selected");

    mode_keep_a: assert property (@(posedge mclk) disable iff (reset)
        s_mode_odd |=> $stable(dout_mode1))
        else $error("mode changed on reserved bits");

    clear_val_a: assert property (@(posedge mclk) disable iff (reset)
        (clearing && strap_done_q) |=> dac_q == $past(rst_code) && dac_code == $past(rst_code) && !shutdown)
        else $error("clear value wrong");

    reset_code_a: assert property (@(posedge mclk) disable iff (reset)
        clearing |=> dac_q == ($past(rsel_s) ? CODE_MIDSCALE : CODE_ZERO))
        else $error("reset code wrong");

    nop_keep_a: assert property (@(posedge mclk) disable iff (reset)
        (do_cmd && cmd == CMD_NOP && clear_n_s && !lock_fall && !powerdown_s) |=> $stable(dac_q) && $stable(sd_q))
        else $error("nop changed state");

    shift_idle_a: assert property (@(posedge mclk) disable iff (reset)
        !selected |=> $stable(shift_q))
        else $error("shift while deselected");

    shift_take_a: assert property (@(posedge mclk) disable iff (reset)
        shift_en |=> shift_q == $past(shift_d))
        else $error("serial bit not taken");

    pin_enter_a: assert property (@(posedge mclk) disable iff (reset)
        (powerdown_s && lock_n_s && !wake) |=> shutdown)
        else $error("powerdown pin ignored");

    pin_stay_a: assert property (@(posedge mclk) disable iff (reset)
        (sd_q && !wake) |=> shutdown)
        else $error("shutdown left without wake");

    wake_wins_a: assert property (@(posedge mclk) disable iff (reset)
        (wake && sd_enter) |=> !shutdown)
        else $error("wake lost to enter");

    oe_off_a: assert property (@(posedge mclk) disable iff (reset)
        sd_q |-> !dac_output_enable)
        else $error("output driven in shutdown");

    sd_keep_in_a: assert property (@(posedge mclk) disable iff (reset)
        (sd_enter && !clearing && !c_ldin) |=> $stable(in_q))
        else $error("shutdown lost input register");

    // mode 0 moves dout on falls, mode 1 on rises
    dout_fall_a: assert property (@(posedge mclk) disable iff (reset)
        (!mode1_q && sclk_fall && selected) |=> dout == $past(shift_q[15]))
        else $error("dout mode 0 wrong");

    dout_rise_a: assert property (@(posedge mclk) disable iff (reset)
        (mode1_q && sclk_rise && selected) |=> dout == $past(shift_q[15]))
        else $error("dout mode 1 wrong");

    dout_hold_a: assert property (@(posedge mclk) disable iff (reset)
        !selected |=> $stable(dout))
        else $error("dout moved while deselected");

endmodule
`default_nettype wire

// ---- dacsc_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module dacsc_host
    import dacsc_pkg::*;
(
    // clock
    input  wire logic mclk,
    // serial link
    output var  logic cs_n,
    output var  logic sclk,
    output var  logic din,
    input  wire logic dout
);
    logic [15:0] rx_word;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
        rx_word = 16'h0000;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // ****
    // one bit: 4 mclk low, 4 high, 2.5 MHz
    // ****
    task automatic put_bit(input logic b);
        din <= b;
        tick(4);
        rx_word <= {rx_word[14:0], dout};
        sclk <= 1'b1;
        tick(4);
        sclk <= 1'b0;
    endtask

    // long adds four leading ones; split pauses between bytes
    task automatic send(input logic [15:0] w, input logic long_frame, input logic split);
        int i;
        cs_n <= 1'b0;
        tick(4);
        for (i = long_frame ? 19 : 15; i >= 0; i--) begin
            put_bit(i > 15 ? 1'b1 : (i == 0 ? 1'b0 : w[i]));
            if (split && i == 8) begin
                tick(10);
            end
        end
        tick(4);
        cs_n <= 1'b1;
        din <= ~din;
        tick(8);
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import dacsc_pkg::*;
    logic        mclk, reset, clear_n, reset_value_select, shutdown_lockout_n, powerdown_pin;
    logic        cs_n, sclk, din, dout, user_output_pin, dac_output_enable, shutdown, dout_mode1;
    logic [11:0] dac_code, input_code;
    int          fail_count = 0;
    int          compares = 0;

    dacsc_core dacsc_core_inst (.mclk(mclk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .din(din),
        .dout(dout), .clear_n(clear_n), .reset_value_select(reset_value_select),
        .shutdown_lockout_n(shutdown_lockout_n), .powerdown_pin(powerdown_pin),
        .user_output_pin(user_output_pin), .dac_code(dac_code), .input_code(input_code),
        .dac_output_enable(dac_output_enable), .shutdown(shutdown), .dout_mode1(dout_mode1));
    dacsc_host dacsc_host_inst (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));

    always #25 mclk = ~mclk;

    // ****
    // helpers
    // ****
    function automatic logic [15:0] fr(input logic [2:0] c, input logic [11:0] d);
        return {c, d, 1'b0};
    endfunction

    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****
    // sequence
    // ****
    initial begin
        mclk = 1'b0;
        reset = 1'b1;
        clear_n = 1'b0;
        reset_value_select = 1'b1;
        shutdown_lockout_n = 1'b0;
        powerdown_pin = 1'b0;
        wait_clk(5);
        reset <= 1'b0;
        wait_clk(8);
        check(shutdown, 1'b0);
        check(dout_mode1, 1'b0);
        check(user_output_pin, 1'b0);
        check(dac_code, CODE_MIDSCALE);
        reset_value_select <= 1'b0;
        wait_clk(8);
        check(dac_code, CODE_ZERO);
        clear_n <= 1'b1;
        dacsc_host_inst.send(fr(CMD_LOAD_IN, 12'habc), 1'b0, 1'b0);
        check(input_code, 12'habc);
        check(dac_code, CODE_ZERO);
        dacsc_host_inst.send(fr(CMD_UPDATE, 12'h555), 1'b0, 1'b0);
        check(dac_code, 12'habc);
        check(dacsc_host_inst.rx_word, fr(CMD_LOAD_IN, 12'habc));
        dacsc_host_inst.send(fr(CMD_LOAD_ALL, 12'h123), 1'b0, 1'b1);
        check({input_code, dac_code}, 24'h123123);
        dacsc_host_inst.send(fr(CMD_NOP, 12'hfff), 1'b0, 1'b0);
        check({input_code, dac_code}, 24'h123123);
        dacsc_host_inst.send(fr(CMD_UOUT_HIGH, 12'h000), 1'b0, 1'b0);
        check(user_output_pin, 1'b1);
        dacsc_host_inst.send(fr(CMD_UOUT_LOW, 12'hfff), 1'b0, 1'b0);
        check(user_output_pin, 1'b0);
        dacsc_host_inst.send(fr(CMD_SHUTDOWN, 12'h000), 1'b0, 1'b0);
        check(shutdown, 1'b0);
        powerdown_pin <= 1'b1;
        wait_clk(8);
        check(shutdown, 1'b0);
        powerdown_pin <= 1'b0;
        shutdown_lockout_n <= 1'b1;
        wait_clk(8);
        dacsc_host_inst.send(fr(CMD_SHUTDOWN, 12'h000), 1'b0, 1'b0);
        check({shutdown, dac_output_enable}, 2'b10);
        check(input_code, 12'h123);
        dacsc_host_inst.send(fr(CMD_LOAD_IN, 12'h456), 1'b0, 1'b0);
        check(input_code, 12'h456);
        dacsc_host_inst.send(fr(CMD_UPDATE, 12'h000), 1'b0, 1'b0);
        check({shutdown, dac_output_enable, dac_code}, {2'b01, 12'h456});
        wait_clk(WAKE_SETTLE_CYCLES);
        powerdown_pin <= 1'b1;
        wait_clk(8);
        powerdown_pin <= 1'b0;
        wait_clk(8);
        check(shutdown, 1'b1);
        shutdown_lockout_n <= 1'b0;
        wait_clk(8);
        check({shutdown, dac_code}, {1'b0, 12'h456});
        shutdown_lockout_n <= 1'b1;
        wait_clk(8);
        dacsc_host_inst.send(fr(CMD_SHUTDOWN, 12'h000), 1'b0, 1'b0);
        dacsc_host_inst.send(fr(CMD_LOAD_ALL, 12'h789), 1'b0, 1'b0);
        check({shutdown, dac_code}, {1'b0, 12'h789});
        dacsc_host_inst.send(fr(CMD_SHUTDOWN, 12'h000), 1'b0, 1'b0);
        clear_n <= 1'b0;
        wait_clk(8);
        check({shutdown, dac_code}, {1'b0, CODE_ZERO});
        clear_n <= 1'b1;
        dacsc_host_inst.send(fr(CMD_MODE, 12'h800), 1'b0, 1'b0);
        check(dout_mode1, 1'b1);
        dacsc_host_inst.send(fr(CMD_MODE, 12'h400), 1'b0, 1'b0);
        check(dout_mode1, 1'b1);
        check(dacsc_host_inst.rx_word, 16'hf800);
        dacsc_host_inst.send(fr(CMD_MODE, 12'h000), 1'b0, 1'b0);
        check(dout_mode1, 1'b0);
        dacsc_host_inst.send(fr(CMD_LOAD_IN, 12'h2c7), 1'b1, 1'b0);
        check(input_code, 12'h2c7);
        stop_test();
    end

    initial begin
        wait_clk(40000);
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
